// *** srw_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module srw_assertions #(
  parameter int HOLD_SHORT   = 40,
  parameter int KICK_WINDOW  = 200,
  parameter bit ACTIVE_HIGH  = 1'h0,
  parameter bit HAS_WATCHDOG = 1'h1
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_undervoltage,
  input wire logic i_manual_reset_n,
  input wire logic i_watchdog_kick_input,
  input wire logic o_reset,
  input wire logic o_reset_active
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  logic kick_q;
  int   idle_q, idle_d;
  // Counts running cycles since the last kick edge
  always_comb idle_d = (!HAS_WATCHDOG || o_reset_active || kick_q != i_watchdog_kick_input) ? 0 : idle_q + 1;
  always_ff @(posedge i_clock) begin
    kick_q <= i_watchdog_kick_input;
    idle_q <= i_rstn ? idle_d : 0;
  end
  sequence mr_low; (!i_manual_reset_n)[*8] ##1 (!i_manual_reset_n)[*8]; endsequence
  pol_inv_a: assert property (o_reset == (ACTIVE_HIGH ? o_reset_active : !o_reset_active)) else $error("pol");
  uv_set_a: assert property (i_undervoltage |-> ##2 o_reset_active) else $error("uv");
  uv_hold_a: assert property ($fell(i_undervoltage) |-> ##2 o_reset_active[*8]) else $error("uvh");
  hold_min_a: assert property ($fell(o_reset_active) |-> $past(o_reset_active, HOLD_SHORT)) else $error("min");
  mr_set_a: assert property (mr_low |-> ##[0:4] o_reset_active) else $error("mr");
  mr_stay_a: assert property (!i_manual_reset_n && o_reset_active |=> o_reset_active) else $error("mrs");
  wd_bound_a: assert property (idle_q <= KICK_WINDOW + 6) else $error("wd");
  wd_clr_a: assert property ($fell(o_reset_active) |=> !o_reset_active) else $error("wdc");
endmodule // srw_assertions
bind srw_supervisor srw_assertions #(
  .HOLD_SHORT   (HOLD_SHORT),
  .KICK_WINDOW  (KICK_WINDOW),
  .ACTIVE_HIGH  (ACTIVE_HIGH),
  .HAS_WATCHDOG (HAS_WATCHDOG)
) chk_u (
  .i_clock               (i_clock),
  .i_rstn                (i_rstn),
  .i_undervoltage        (i_undervoltage),
  .i_manual_reset_n      (i_manual_reset_n),
  .i_watchdog_kick_input (i_watchdog_kick_input),
  .o_reset               (o_reset),
  .o_reset_active        (o_reset_active)
);
`default_nettype wire

// *** srw_cpu.sv ***
`timescale 1ns/1ps
`default_nettype none
module srw_cpu (
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  input  wire logic i_run,
  output var  logic o_kick = 1'b0
);
  int n = 0;
  // Level flipped at one program point only; a halted core stops kicking
  always @(negedge i_clock) begin
    n = (i_reset_n && i_run) ? n + 1 : 0;
    if (n % 50 == 49) o_kick = ~o_kick;
  end
endmodule // srw_cpu
`default_nettype wire

// *** srw_input_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module srw_input_sync (
  input  wire logic   i_clock,
  input  wire logic   i_rstn,
  input  wire logic   i_manual_reset_n,
  input  wire logic   i_watchdog_kick_input,
  srw_sync_if.src     o_sync
);
  logic [1:0] mr_q;
  logic [1:0] mr_d;
  logic [1:0] kick_q;
  logic [1:0] kick_d;

  // Two flops per pin; the first stage feeds only the second
  always_comb begin
    mr_d   = {mr_q[0], i_manual_reset_n};
    kick_d = {kick_q[0], i_watchdog_kick_input};
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      mr_q   <= 2'h3;
      kick_q <= 2'h0;
    end else begin
      mr_q   <= mr_d;
      kick_q <= kick_d;
    end
  end

  assign o_sync.mr_n_level = mr_q[1];
  assign o_sync.kick_level = kick_q[1];
endmodule // srw_input_sync
`default_nettype wire

// *** srw_params.svh ***
`ifndef SRW_PARAMS_SVH
`define SRW_PARAMS_SVH

// Hold spans, as minimum times in ms
`define SRW_HOLD_SHORT_MS  10
`define SRW_HOLD_LONG_MS   150
// Watchdog kick window in ms
`define SRW_KICK_WINDOW_MS 1500
// Minimum kick pulse width in ns
`define SRW_KICK_MIN_NS    150
// Clock period in ns
`define SRW_CLK_NS         5
// Manual reset debounce time in us
`define SRW_DEBOUNCE_US    1000
// Reset value of the hold counter
`define SRW_CNT_RESET      32'h0000_0000

`endif

// *** srw_pkg.sv ***
package srw_pkg;
  typedef enum logic [1:0] {
    SRW_ST_HOLD,
    SRW_ST_RUN
  } srw_state_t;
endpackage

// *** srw_supervisor.sv ***
// Summary of operation
// - Undervoltage asserts reset, polarity per variant
// - After undervoltage clears, hold full span
// - Manual low holds reset, then span
// - Debounce switch: one clean reset per press
// - No kick toggle within window causes reset
// - Watchdog clears on reset, manual, edges
// - Accept kick pulses down to 150ns
// - Watchdog halted during reset, resumes after
// - Choice pin: low short, high long span; first span after reset is short
// - Choice change applies only after span
`timescale 1ns/1ps
`default_nettype none
`include "srw_params.svh"
module srw_supervisor
  import srw_pkg::*;
#(
  parameter int unsigned CLK_NS       = `SRW_CLK_NS,
  parameter int unsigned HOLD_SHORT   = (`SRW_HOLD_SHORT_MS * 1000000 + CLK_NS - 1) / CLK_NS,
  parameter int unsigned HOLD_LONG    = (`SRW_HOLD_LONG_MS * 1000000 + CLK_NS - 1) / CLK_NS,
  parameter int unsigned KICK_WINDOW  = (`SRW_KICK_WINDOW_MS * 1000000) / CLK_NS,
  parameter int unsigned DEBOUNCE     = (`SRW_DEBOUNCE_US * 1000 + CLK_NS - 1) / CLK_NS,
  parameter bit          ACTIVE_HIGH  = 1'b0,
  parameter bit          HAS_WATCHDOG = 1'b1,
  parameter int unsigned CW           = 32
) (
  input  wire logic i_clock,
  input  wire logic i_rstn,
  input  wire logic i_undervoltage,
  input  wire logic i_manual_reset_n,
  input  wire logic i_watchdog_kick_input,
  input  wire logic i_hold_period_choice,
  output var  logic o_reset,
  output var  logic o_reset_active
);
  // A minimum-width kick pulse spans many clocks, so the two-flop sampler cannot miss it
  srw_sync_if sync_bus ();

  // Input stage
  logic [1:0]    choice_q;
  logic [1:0]    choice_d;
  logic          uv_q;
  logic          uv_d;
  logic          kick_prev_q;
  logic          kick_prev_d;
  // Manual reset debounce
  logic [CW-1:0] deb_cnt_q;
  logic [CW-1:0] deb_cnt_d;
  logic          mr_deb_q;
  logic          mr_deb_d;
  // Supervisor state
  srw_state_t    state_q;
  srw_state_t    state_d;
  logic [CW-1:0] hold_cnt_q;
  logic [CW-1:0] hold_cnt_d;
  logic [CW-1:0] hold_len_q;
  logic [CW-1:0] hold_len_d;
  logic [CW-1:0] wd_cnt_q;
  logic [CW-1:0] wd_cnt_d;
  // Registered outputs
  logic          reset_q;
  logic          reset_d;
  logic          active_q;
  logic          active_d;
  // Decoded conditions
  logic          kick_edge;
  logic          cause;
  logic          wd_expire;
  logic          hold_done;

  srw_input_sync u_sync (
    .i_clock               (i_clock),
    .i_rstn                (i_rstn),
    .i_manual_reset_n      (i_manual_reset_n),
    .i_watchdog_kick_input (i_watchdog_kick_input),
    .o_sync                (sync_bus.src)
  );

  function automatic logic [CW-1:0] span_for(input logic long_sel);
    span_for = long_sel ? CW'(HOLD_LONG) : CW'(HOLD_SHORT);
  endfunction

  // Terminal-count test shared by the debounce, hold and watchdog counters
  function automatic logic reached(input logic [CW-1:0] cnt, input logic [CW-1:0] last);
    reached = (cnt >= last);
  endfunction

  // Input stage: choice pin is a pin, undervoltage comes from logic on this clock
  always_comb begin
    choice_d    = {choice_q[0], i_hold_period_choice};
    uv_d        = i_undervoltage;
    kick_prev_d = sync_bus.kick_level;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      choice_q    <= 2'h0;
      // Undervoltage is taken as present until the first clean sample
      uv_q        <= 1'h1;
      kick_prev_q <= 1'h0;
    end else begin
      choice_q    <= choice_d;
      uv_q        <= uv_d;
      kick_prev_q <= kick_prev_d;
    end
  end

  // Debounce: any bounce restarts the count, so one press gives one level change
  always_comb begin
    mr_deb_d  = mr_deb_q;
    deb_cnt_d = '0;
    if (sync_bus.mr_n_level != mr_deb_q) begin
      if (reached(deb_cnt_q, CW'(DEBOUNCE - 1))) begin
        mr_deb_d = sync_bus.mr_n_level;
      end else begin
        deb_cnt_d = deb_cnt_q + 1'h1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      mr_deb_q  <= 1'h1;
      deb_cnt_q <= CW'(`SRW_CNT_RESET);
    end else begin
      mr_deb_q  <= mr_deb_d;
      deb_cnt_q <= deb_cnt_d;
    end
  end

  always_comb begin
    kick_edge = HAS_WATCHDOG && (sync_bus.kick_level != kick_prev_q);
    wd_expire = HAS_WATCHDOG && reached(wd_cnt_q, CW'(KICK_WINDOW - 1));
    hold_done = reached(hold_cnt_q, hold_len_q - 1'h1);
    cause     = uv_q || !mr_deb_q;
  end

  // Span length is only reloaded in RUN, so a choice change during a span waits for the next one
  always_comb begin
    state_d    = state_q;
    hold_cnt_d = hold_cnt_q;
    hold_len_d = hold_len_q;
    wd_cnt_d   = wd_cnt_q;
    unique case (state_q)
      SRW_ST_HOLD: begin
        wd_cnt_d = '0;
        if (cause) begin
          hold_cnt_d = '0;
        end else if (hold_done) begin
          state_d    = SRW_ST_RUN;
          hold_cnt_d = '0;
        end else begin
          hold_cnt_d = hold_cnt_q + 1'h1;
        end
      end
      SRW_ST_RUN: begin
        hold_len_d = span_for(choice_q[1]);
        if (cause || wd_expire) begin
          state_d    = SRW_ST_HOLD;
          hold_cnt_d = '0;
          wd_cnt_d   = '0;
        end else if (kick_edge) begin
          wd_cnt_d = '0;
        end else if (HAS_WATCHDOG) begin
          wd_cnt_d = wd_cnt_q + 1'h1;
        end
      end
      default: begin
        state_d = SRW_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state_q    <= SRW_ST_HOLD;
      hold_cnt_q <= CW'(`SRW_CNT_RESET);
      // First span after reset is the short one; the choice pin is not yet sampled
      hold_len_q <= CW'(HOLD_SHORT);
      wd_cnt_q   <= CW'(`SRW_CNT_RESET);
    end else begin
      state_q    <= state_d;
      hold_cnt_q <= hold_cnt_d;
      hold_len_q <= hold_len_d;
      wd_cnt_q   <= wd_cnt_d;
    end
  end

  // Outputs are built from the next state so they move on the same edge as it
  always_comb begin
    active_d = (state_d == SRW_ST_HOLD);
    reset_d  = ACTIVE_HIGH ? active_d : !active_d;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      reset_q  <= ACTIVE_HIGH;
      active_q <= 1'h1;
    end else begin
      reset_q  <= reset_d;
      active_q <= active_d;
    end
  end

  assign o_reset        = reset_q;
  assign o_reset_active = active_q;
endmodule // srw_supervisor
`default_nettype wire

// *** srw_sync_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface srw_sync_if;
  logic mr_n_level;
  logic kick_level;
  modport src (output mr_n_level, output kick_level);
  modport dst (input mr_n_level, input kick_level);
endinterface
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int HS = 40, HL = 100, KW = 200;
  logic clk = 0, rstn = 0, uv = 0, mr_n = 1, pl = 0, ct = 0, run = 0, rst_n, act, kick, rst_hi;
  int miscompares = 0, comparisons = 0, n;
  srw_supervisor #(.HOLD_SHORT(HS), .HOLD_LONG(HL), .KICK_WINDOW(KW), .DEBOUNCE(8)) dut_u (.i_clock(clk),
    .i_rstn(rstn), .i_undervoltage(uv), .i_manual_reset_n(mr_n), .i_watchdog_kick_input(kick ^ pl),
    .i_hold_period_choice(ct), .o_reset(rst_n), .o_reset_active(act));
  // Second copy: active-high output and no watchdog, fed the same stimulus
  srw_supervisor #(.HOLD_SHORT(HS), .HOLD_LONG(HL), .KICK_WINDOW(KW), .DEBOUNCE(8), .ACTIVE_HIGH(1'h1),
    .HAS_WATCHDOG(1'h0)) dut_hi_u (.i_clock(clk), .i_rstn(rstn), .i_undervoltage(uv), .i_manual_reset_n(mr_n),
    .i_watchdog_kick_input(kick ^ pl), .i_hold_period_choice(ct), .o_reset(rst_hi), .o_reset_active());
  srw_cpu cpu_u (.i_clock(clk), .i_reset_n(rst_n), .i_run(run), .o_kick(kick));
  initial forever #2.5 clk = ~clk;
  initial begin #50us; miscompares++; report_and_stop; end
  task report_and_stop;
    $display("%0d checks, %0d mismatches", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task check(string s, logic e, logic g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", s, e, g);
    end
  endtask
  task cyc(int k); repeat (k) @(negedge clk); endtask
  task hold(logic v);
    n = 0;
    while (act === v && n < 999) begin cyc(1); n++; end
    if (n >= 999) begin
      $display("ERROR hold_limit expected change seen none");
      miscompares++;
      report_and_stop;
    end
  endtask
  task uv_hit;
    uv = 1;
    cyc(4);
    check("pin", 1'b0, rst_n);
    check("pin_hi", 1'b1, rst_hi);
    uv = 0;
    hold(1);
  endtask
  task t_uv;
    uv_hit;
    check("short", 1'b1, n >= HS && n <= HS + 4);
  endtask
  task t_mr;
    repeat (3) begin mr_n = 0; cyc(3); mr_n = 1; cyc(2); end
    mr_n = 0;
    cyc(30);
    check("mr", 1'b1, act);
    mr_n = 1;
    hold(1);
    check("mr_span", 1'b1, n >= HS + 8 && n <= HS + 16);
  endtask
  task t_wd;
    run = 0;
    uv_hit;
    hold(0);
    check("wd", 1'b1, n >= KW - 1 && n <= KW + 4);
    check("no_wd", 1'b0, rst_hi);
    ct = 1;
    hold(1);
    check("defer", 1'b1, n >= HS - 1 && n <= HS + 4);
    run = 1;
    uv_hit;
    check("long", 1'b1, n >= HL && n <= HL + 4);
    ct = 0;
  endtask
  task t_kick;
    run = 0;
    repeat (4) begin pl = 1; cyc(30); pl = 0; cyc(180); end
    check("pulse", 1'b0, act);
  endtask
  initial begin
    cyc(16);
    rstn = 1;
    run = 1;
    cyc(60);
    t_uv;
    t_mr;
    t_wd;
    t_kick;
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
